/* hdl/adc_seq.sv */
// file: three-group converter sequencer with result fifos and apb registers
//
// Design decisions made here: the address map and the APB register port.
`timescale 1ns/1ps
module adc_seq
    import adc_pkg::*;
#(
    parameter int PCLK_RATIO = PCLK_DIV,
    parameter int CONV_LEN = CONV_TICKS
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // analog front end
    input wire logic [RES_W-1:0] conv_result,
    output logic [CHAN_W-1:0] conv_chan,
    output logic conv_busy,
    // interrupt
    output logic irq
);
    localparam int DIV_W = $clog2(PCLK_RATIO) + 1;
    localparam int TICK_W = $clog2(CONV_LEN) + 1;
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(PCLK_RATIO - 1);
    localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(CONV_LEN - 1);
    localparam int LVL_W = $clog2(FIFO_DEPTH) + 1;
    localparam int ENTRY_W = CHAN_W + RES_W;

    // reset release
    logic rst_meta;
    logic rst_sync_b;
    // peripheral clock enable
    logic [DIV_W-1:0] div_cnt;
    logic [DIV_W-1:0] next_div_cnt;
    logic pclk_tick;
    // registers
    logic [7:0] ctrl1;
    logic [7:0] next_ctrl1;
    logic [2:0] mode;
    logic [2:0] next_mode;
    logic [5:0] mask;
    logic [5:0] next_mask;
    logic [NUM_CHAN-1:0] sel [NUM_GROUPS];
    logic [NUM_CHAN-1:0] next_sel [NUM_GROUPS];
    logic ack;
    logic next_ack;
    logic [31:0] next_prdata;
    logic [2:0] pop_arm;
    logic [2:0] next_pop_arm;
    // bus decode
    logic acc;
    logic wr_fire;
    logic rd_fire;
    logic hit;
    logic [2:0] sel_hit;
    logic [2:0] fifo_hit;
    logic [2:0] sel_wr_evt;
    logic [31:0] rdata;
    logic [5:0] st_clr;
    // sequencer
    seq_state_t state;
    seq_state_t next_state;
    result_t cur;
    result_t next_cur;
    logic [TICK_W-1:0] tick;
    logic [TICK_W-1:0] next_tick;
    logic [NUM_CHAN-1:0] pend [NUM_GROUPS];
    logic [NUM_CHAN-1:0] next_pend [NUM_GROUPS];
    logic [THR_W-1:0] thresh [NUM_GROUPS];
    logic [THR_W-1:0] next_thresh [NUM_GROUPS];
    logic [5:0] status;
    logic [5:0] next_status;
    logic [5:0] set_ev;
    logic [2:0] push;
    logic [2:0] flush;
    logic [2:0] req;
    logic [2:0] busy;
    logic [1:0] pick;
    logic other_req;
    logic en;
    logic [2:0] frz;
    // fifo side
    logic [2:0] fifo_in_ready;
    logic [2:0] fifo_out_valid;
    logic [2:0] fifo_pop;
    logic [ENTRY_W-1:0] fifo_data [NUM_GROUPS];
    logic [LVL_W-1:0] fifo_level [NUM_GROUPS];

    function automatic logic [CHAN_W-1:0] first_chan(input logic [NUM_CHAN-1:0] m);
        logic [CHAN_W-1:0] c;
        c = '0;
        for (int i = NUM_CHAN - 1; i >= 0; i--) begin
            if (m[i]) begin
                c = CHAN_W'(i);
            end
        end
        return c;
    endfunction : first_chan

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_meta <= 1'b0;
            rst_sync_b <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync_b <= rst_meta;
        end
    end

    // peripheral clock as a one-cycle enable
    assign pclk_tick = (div_cnt == DIV_LAST);
    assign next_div_cnt = pclk_tick ? '0 : div_cnt + 1'b1;

    always_ff @(posedge sys_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            div_cnt <= '0;
        end else begin
            div_cnt <= next_div_cnt;
        end
    end

    assign en = ctrl1[EN_BIT];
    assign frz = ctrl1[FRZ_LSB +: 3];
    assign acc = psel & penable;
    assign wr_fire = acc & ack & pwrite;
    assign rd_fire = acc & ack & ~pwrite;
    assign pready = ack;
    assign pslverr = acc & ack & ~hit;
    assign sel_wr_evt = wr_fire ? sel_hit : 3'b000;
    assign st_clr = (wr_fire && paddr == OFF_STATUS) ? pwdata[5:0] : 6'h00;
    assign fifo_pop = rd_fire ? pop_arm : 3'b000;
    assign irq = |(status & mask);
    assign conv_chan = cur.chan;
    assign conv_busy = (state == ST_CONV);

    always_comb begin
        hit = 1'b0;
        sel_hit = '0;
        fifo_hit = '0;
        rdata = '0;
        if (paddr == OFF_CTRL1) begin
            hit = 1'b1;
            rdata[7:0] = ctrl1;
        end else if (paddr == OFF_MODE) begin
            hit = 1'b1;
            rdata[2:0] = mode;
        end else if (paddr == OFF_STATUS) begin
            hit = 1'b1;
            rdata[EV_W-1:0] = status;
            rdata[BUSY_LSB +: 3] = busy;
        end else if (paddr == OFF_MASK) begin
            hit = 1'b1;
            rdata[5:0] = mask;
        end else if (paddr == OFF_THRESH) begin
            hit = 1'b1;
            rdata[3*THR_W-1:0] = {thresh[2], thresh[1], thresh[0]};
        end else begin
            for (int g = 0; g < NUM_GROUPS; g++) begin
                if (paddr == OFF_SEL0 + OFF_STEP * 8'(g)) begin
                    hit = 1'b1;
                    sel_hit[g] = 1'b1;
                    rdata[NUM_CHAN-1:0] = sel[g];
                end else if (paddr == OFF_FIFO0 + OFF_STEP * 8'(g)) begin
                    hit = 1'b1;
                    fifo_hit[g] = 1'b1;
                    if (fifo_out_valid[g]) begin
                        rdata[RES_W-1:0] = fifo_data[g][RES_W-1:0];
                        rdata[CHAN_LSB +: CHAN_W] = fifo_data[g][ENTRY_W-1:RES_W];
                    end
                end
            end
        end
    end

    // register file and bus answer: one wait state, data latched before pready
    always_comb begin
        next_ctrl1 = ctrl1;
        next_mode = mode;
        next_mask = mask;
        next_sel = sel;
        next_ack = acc & ~ack;
        next_prdata = prdata;
        next_pop_arm = pop_arm;
        if (acc && !ack) begin
            next_prdata = rdata;
            // pop only what was shown to the master
            next_pop_arm = (!pwrite) ? (fifo_hit & fifo_out_valid) : 3'b000;
        end
        if (wr_fire && paddr == OFF_CTRL1) begin
            next_ctrl1 = pwdata[7:0] & CTRL1_WMASK;
        end
        if (wr_fire && paddr == OFF_MODE) begin
            next_mode = pwdata[2:0];
        end
        if (wr_fire && paddr == OFF_MASK) begin
            next_mask = pwdata[5:0];
        end
        for (int g = 0; g < NUM_GROUPS; g++) begin
            if (sel_wr_evt[g]) begin
                next_sel[g] = pwdata[NUM_CHAN-1:0];
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            ctrl1 <= CTRL1_RST;
            mode <= MODE_RST;
            mask <= MASK_RST;
            for (int g = 0; g < NUM_GROUPS; g++) begin
                sel[g] <= SEL_RST;
            end
            ack <= 1'b0;
            prdata <= '0;
            pop_arm <= '0;
        end else begin
            ctrl1 <= next_ctrl1;
            mode <= next_mode;
            mask <= next_mask;
            sel <= next_sel;
            ack <= next_ack;
            prdata <= next_prdata;
            pop_arm <= next_pop_arm;
        end
    end

    // requests and fixed-priority pick, group 0 first
    always_comb begin
        pick = '0;
        for (int g = 0; g < NUM_GROUPS; g++) begin
            req[g] = |pend[g];
            busy[g] = req[g] | ((state != ST_IDLE) && (cur.group == 2'(g)));
        end
        for (int g = NUM_GROUPS - 1; g >= 0; g--) begin
            if (req[g]) begin
                pick = 2'(g);
            end
        end
        other_req = |(req & ~(3'b001 << cur.group));
    end

    always_comb begin
        next_state = state;
        next_cur = cur;
        next_tick = tick;
        next_pend = pend;
        next_thresh = thresh;
        set_ev = '0;
        push = '0;
        flush = '0;
        case (state)
            ST_IDLE: begin
                if (en && (|req) && pclk_tick) begin
                    next_cur.group = pick;
                    next_cur.chan = first_chan(pend[pick]);
                    next_pend[pick][first_chan(pend[pick])] = 1'b0;
                    next_tick = '0;
                    next_state = ST_CONV;
                end
            end
            ST_CONV: begin
                if (pclk_tick) begin
                    if (tick == TICK_LAST) begin
                        next_cur.data = conv_result;
                        next_state = ST_DONE;
                    end else begin
                        next_tick = tick + 1'b1;
                    end
                end
            end
            ST_DONE: begin
                // the tag travels with the result, so it reaches its owner
                push[cur.group] = 1'b1;
                if (fifo_in_ready[cur.group]) begin
                    next_thresh[cur.group] = thresh[cur.group] + 1'b1;
                end else begin
                    set_ev[OVR_LSB + 32'(cur.group)] = 1'b1;
                end
                if (pend[cur.group] == '0) begin
                    set_ev[END_LSB + 32'(cur.group)] = 1'b1;
                    if (mode[cur.group]) begin
                        next_pend[cur.group] = sel[cur.group];
                    end
                    next_state = ST_IDLE;
                end else if (frz[cur.group] && other_req) begin
                    next_state = ST_IDLE;
                end else begin
                    next_cur.chan = first_chan(pend[cur.group]);
                    next_pend[cur.group][first_chan(pend[cur.group])] = 1'b0;
                    next_tick = '0;
                    next_state = ST_CONV;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
        for (int g = 0; g < NUM_GROUPS; g++) begin
            if (sel_wr_evt[g]) begin
                if (pwdata[NUM_CHAN-1:0] == '0) begin
                    next_pend[g] = '0;
                    next_thresh[g] = '0;
                    flush[g] = 1'b1;
                    set_ev[END_LSB + g] = 1'b0;
                    set_ev[OVR_LSB + g] = 1'b0;
                    // also cancels a start picked for this group in this cycle
                    if (next_state != ST_IDLE && next_cur.group == 2'(g)) begin
                        next_state = ST_IDLE;
                    end
                end else begin
                    next_pend[g] = pwdata[NUM_CHAN-1:0];
                end
            end
        end
        if (!en) begin
            for (int g = 0; g < NUM_GROUPS; g++) begin
                next_pend[g] = '0;
            end
            next_state = ST_IDLE;
            push = '0;
            set_ev = '0;
        end
        next_status = (status & ~st_clr) | set_ev;
    end

    always_ff @(posedge sys_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            state <= ST_IDLE;
            cur <= '0;
            tick <= '0;
            for (int g = 0; g < NUM_GROUPS; g++) begin
                pend[g] <= '0;
                thresh[g] <= '0;
            end
            status <= STATUS_RST;
        end else begin
            state <= next_state;
            cur <= next_cur;
            tick <= next_tick;
            pend <= next_pend;
            thresh <= next_thresh;
            status <= next_status;
        end
    end

    for (genvar g = 0; g < NUM_GROUPS; g++) begin : g_fifo
        result_fifo #(
            .WIDTH(ENTRY_W),
            .DEPTH(FIFO_DEPTH)
        ) u_fifo (
            .clk(sys_clk),
            .rst_b(rst_sync_b),
            .flush(flush[g]),
            .in_valid(push[g]),
            .in_ready(fifo_in_ready[g]),
            .in_data({cur.chan, cur.data}),
            .out_valid(fifo_out_valid[g]),
            .out_ready(fifo_pop[g]),
            .out_data(fifo_data[g]),
            .level(fifo_level[g])
        );
    end

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_sync_b);

    sequence s_pass_end0;
        state == ST_DONE && cur.group == 2'd0 && pend[0] == '0 && en && !sel_wr_evt[0];
    endsequence
    sequence s_conv_finish;
        state == ST_CONV && pclk_tick && tick == TICK_LAST && en && sel_wr_evt == 3'b000
            ##1 en && sel_wr_evt == 3'b000;
    endsequence

    property p_disable_idles;
        !en |=> state == ST_IDLE;
    endproperty
    a_disable_idles: assert property (p_disable_idles) else $error("converter active while disabled");
    property p_disable_clears;
        $fell(en) |=> pend[0] == '0 && pend[1] == '0 && pend[2] == '0;
    endproperty
    a_disable_clears: assert property (p_disable_clears) else $error("group state kept after disable");
    property p_end_flag;
        s_pass_end0 |=> status[END_LSB];
    endproperty
    a_end_flag: assert property (p_end_flag) else $error("conversion-end flag not set");
    property p_continuous;
        s_pass_end0 ##0 mode[0] |=> pend[0] == $past(sel[0]);
    endproperty
    a_continuous: assert property (p_continuous) else $error("continuous group not reloaded");
    property p_owner;
        state == ST_DONE && en && flush == 3'b000 |-> push == (3'b001 << cur.group);
    endproperty
    a_owner: assert property (p_owner) else $error("result sent to wrong fifo");
    property p_freeze_yield;
        state == ST_DONE && en && frz[cur.group] && other_req && pend[cur.group] != '0
            && sel_wr_evt == 3'b000 |=> state == ST_IDLE;
    endproperty
    a_freeze_yield: assert property (p_freeze_yield) else $error("freezable group did not yield");
    property p_push_counts;
        state == ST_DONE && cur.group == 2'd0 && en && fifo_in_ready[0] && !sel_wr_evt[0]
            |=> thresh[0] == THR_W'($past(thresh[0]) + 1'b1);
    endproperty
    a_push_counts: assert property (p_push_counts) else $error("threshold count out of step");
    property p_zero_sel;
        sel_wr_evt[0] && pwdata[NUM_CHAN-1:0] == '0 |=> pend[0] == '0 && !fifo_out_valid[0];
    endproperty
    a_zero_sel: assert property (p_zero_sel) else $error("zero select left fifo data");
    property p_store_alone;
        s_conv_finish |-> push[cur.group];
    endproperty
    a_store_alone: assert property (p_store_alone) else $error("finished result not stored");
endmodule : adc_seq

/* hdl/adc_pkg.sv */
// package: constants and types for the three-group converter sequencer
package adc_pkg;
    // sizes
    localparam int NUM_GROUPS = 3;
    localparam int NUM_CHAN = 16;
    localparam int CHAN_W = 4;
    localparam int RES_W = 12;
    localparam int FIFO_DEPTH = 16;
    localparam int THR_W = 8;
    localparam int ADDR_W = 8;
    // register byte offsets
    localparam logic [7:0] OFF_CTRL1 = 8'h00;
    localparam logic [7:0] OFF_MODE = 8'h04;
    localparam logic [7:0] OFF_STATUS = 8'h08;
    localparam logic [7:0] OFF_MASK = 8'h0c;
    localparam logic [7:0] OFF_THRESH = 8'h10;
    localparam logic [7:0] OFF_SEL0 = 8'h20;
    localparam logic [7:0] OFF_FIFO0 = 8'h30;
    localparam logic [7:0] OFF_STEP = 8'h04;
    // field positions
    localparam int EN_BIT = 5;
    localparam int FRZ_LSB = 0;
    localparam int END_LSB = 0;
    localparam int OVR_LSB = 3;
    localparam int BUSY_LSB = 8;
    localparam int EV_W = 6;
    localparam int CHAN_LSB = 16;
    // reset values and write masks
    localparam logic [7:0] CTRL1_RST = 8'h00;
    localparam logic [7:0] CTRL1_WMASK = 8'h27;
    localparam logic [2:0] MODE_RST = 3'h0;
    localparam logic [5:0] MASK_RST = 6'h00;
    localparam logic [5:0] STATUS_RST = 6'h00;
    localparam logic [15:0] SEL_RST = 16'h0000;
    // timing: system clocks per peripheral tick, peripheral ticks per conversion
    localparam int PCLK_DIV = 4;
    localparam int CONV_TICKS = 14;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_CONV = 2'b01,
        ST_DONE = 2'b10
    } seq_state_t;

    typedef struct packed {
        logic [1:0] group;
        logic [CHAN_W-1:0] chan;
        logic [RES_W-1:0] data;
    } result_t;
endpackage : adc_pkg

/* hdl/result_fifo.sv */
// file: flip-flop result fifo with flush, one per conversion group
`timescale 1ns/1ps
module result_fifo
    import adc_pkg::*;
#(
    parameter int WIDTH = 16,
    parameter int DEPTH = FIFO_DEPTH
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // control
    input wire logic flush,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    output logic [$clog2(DEPTH):0] level
);
    localparam int PTR_W = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PTR_W-1:0] rd_ptr;
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] next_rd_ptr;
    logic [PTR_W-1:0] next_wr_ptr;
    logic [PTR_W:0] next_level;
    logic push;
    logic pop;

    assign in_ready = (level != (PTR_W + 1)'(DEPTH));
    assign out_valid = (level != '0);
    assign out_data = mem[rd_ptr];
    assign push = in_valid & in_ready & ~flush;
    assign pop = out_valid & out_ready & ~flush;

    always_comb begin
        next_rd_ptr = rd_ptr;
        next_wr_ptr = wr_ptr;
        next_level = level;
        if (flush) begin
            // drop every stored entry at once
            next_rd_ptr = '0;
            next_wr_ptr = '0;
            next_level = '0;
        end else begin
            if (push) begin
                next_wr_ptr = wr_ptr + 1'b1;
            end
            if (pop) begin
                next_rd_ptr = rd_ptr + 1'b1;
            end
            if (push && !pop) begin
                next_level = level + 1'b1;
            end else if (pop && !push) begin
                next_level = level - 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rd_ptr <= '0;
            wr_ptr <= '0;
            level <= '0;
        end else begin
            rd_ptr <= next_rd_ptr;
            wr_ptr <= next_wr_ptr;
            level <= next_level;
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end
endmodule : result_fifo

/* verification/tb.sv */
// testbench for the three-group converter sequencer over apb
`timescale 1ns/1ps
module tb;
    import adc_pkg::*;

    logic sys_clk;
    logic rst_b;
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [RES_W-1:0] conv_result;
    logic [CHAN_W-1:0] conv_chan;
    logic conv_busy;
    logic irq;
    int failures;
    int checks;
    logic [31:0] rdata;
    logic err;

    adc_seq #(
        .PCLK_RATIO(3),
        .CONV_LEN(4)
    ) u_adc_seq (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .conv_result(conv_result),
        .conv_chan(conv_chan),
        .conv_busy(conv_busy),
        .irq(irq)
    );

    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    // front end answers with a channel-tagged result
    always @(posedge sys_clk) begin
        conv_result <= {8'ha5, conv_chan};
    end

    function automatic logic [31:0] word_of(input logic [3:0] ch);
        return {12'h000, ch, 4'h0, 8'ha5, ch};
    endfunction : word_of

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %0t ns: saw %h, expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic test_done;
        $display("checks %0d, failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : test_done

    // one apb transfer; setup at the next edge, held until pready
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge sys_clk);
        penable <= 1'b1;
        // a hung wait is ended by the watchdog
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        rdata = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rdata, exp);
    endtask : rd_chk

    task automatic cycles(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : cycles

    task automatic wait_busy;
        int n;
        n = 0;
        while (conv_busy !== 1'b1 && n < 40) begin
            @(posedge sys_clk);
            n++;
        end
        if (n >= 40) begin
            failures++;
            $display("[ERR] %0t ns: conversion never started", $time);
        end
    endtask : wait_busy

    initial begin
        #200000;
        failures++;
        $display("[ERR] %0t ns: watchdog expired", $time);
        test_done();
    end

    initial begin
        failures = 0;
        checks = 0;
        rst_b = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        conv_result = 12'h000;
        repeat (4) @(posedge sys_clk);
        rst_b <= 1'b1;
        cycles(4);
        // reset state and refused address
        rd_chk(OFF_CTRL1, 32'h0);
        rd_chk(OFF_STATUS, 32'h0);
        apb(1'b1, 8'hfc, 32'hffff_ffff);
        chk({31'h0, err}, 32'h1);
        rd_chk(8'hfc, 32'h0);
        chk({31'h0, err}, 32'h1);
        $display("test reset done");
        // one channel per group, single mode, no bus traffic while converting
        apb(1'b1, OFF_CTRL1, 32'h20);
        for (int g = 0; g < NUM_GROUPS; g++) begin
            apb(1'b1, 8'(OFF_SEL0 + g * OFF_STEP), 32'h1 << (g + 1));
            cycles(60);
            chk({31'h0, conv_busy}, 32'h0);
            apb(1'b0, OFF_STATUS, 32'h0);
            chk({31'h0, rdata[g]}, 32'h1);
            rd_chk(8'(OFF_FIFO0 + g * OFF_STEP), word_of(4'(g + 1)));
            rd_chk(8'(OFF_FIFO0 + g * OFF_STEP), 32'h0);
        end
        rd_chk(OFF_THRESH, 32'h0001_0101);
        $display("test groups done");
        // interrupt mask and write-one-to-clear
        apb(1'b1, OFF_MASK, 32'h0);
        cycles(2);
        chk({31'h0, irq}, 32'h0);
        apb(1'b1, OFF_MASK, 32'h2);
        cycles(2);
        chk({31'h0, irq}, 32'h1);
        apb(1'b1, OFF_STATUS, 32'h2);
        cycles(2);
        chk({31'h0, irq}, 32'h0);
        rd_chk(OFF_STATUS, 32'h5);
        apb(1'b1, OFF_STATUS, 32'h3f);
        $display("test irq done");
        // continuous mode, then zero select empties group 0
        apb(1'b1, OFF_MODE, 32'h1);
        apb(1'b1, OFF_SEL0, 32'h3);
        cycles(100);
        apb(1'b0, OFF_THRESH, 32'h0);
        chk({31'h0, rdata[7:0] >= 8'h03}, 32'h1);
        rd_chk(OFF_FIFO0, word_of(4'h0));
        rd_chk(OFF_FIFO0, word_of(4'h1));
        apb(1'b1, OFF_MODE, 32'h0);
        apb(1'b1, OFF_SEL0, 32'h0);
        cycles(40);
        rd_chk(OFF_FIFO0, 32'h0);
        rd_chk(OFF_THRESH, 32'h0001_0100);
        chk({31'h0, conv_busy}, 32'h0);
        $display("test continuous done");
        // disable mid-conversion, then clean restart
        apb(1'b1, OFF_SEL1_ADDR(), 32'h1);
        wait_busy();
        apb(1'b1, OFF_CTRL1, 32'h0);
        cycles(40);
        chk({31'h0, conv_busy}, 32'h0);
        rd_chk(OFF_FIFO0 + OFF_STEP, 32'h0);
        apb(1'b1, OFF_CTRL1, 32'h20);
        cycles(40);
        chk({31'h0, conv_busy}, 32'h0);
        apb(1'b1, OFF_STATUS, 32'h3f);
        // recovery: one channel in every group, then clear every select
        for (int g = 0; g < NUM_GROUPS; g++) begin
            apb(1'b1, 8'(OFF_SEL0 + g * OFF_STEP), 32'h4);
        end
        rd_chk(OFF_SEL1_ADDR(), 32'h4);
        cycles(80);
        rd_chk(OFF_STATUS, 32'h7);
        rd_chk(OFF_FIFO0 + OFF_STEP, word_of(4'h2));
        for (int g = 0; g < NUM_GROUPS; g++) begin
            apb(1'b1, 8'(OFF_SEL0 + g * OFF_STEP), 32'h0);
        end
        $display("test enable done");
        // freezable group pre-empted by another group's request
        apb(1'b1, OFF_CTRL1, 32'h24);
        apb(1'b1, 8'(OFF_SEL0 + 2 * OFF_STEP), 32'h3);
        wait_busy();
        apb(1'b1, OFF_SEL0, 32'h10);
        // after the frozen channel ends, group 0 must be served next
        while (conv_busy === 1'b1) begin
            @(posedge sys_clk);
        end
        wait_busy();
        chk({28'h0, conv_chan}, 32'h4);
        cycles(80);
        rd_chk(OFF_FIFO0, word_of(4'h4));
        rd_chk(OFF_FIFO0, 32'h0);
        rd_chk(8'(OFF_FIFO0 + 2 * OFF_STEP), word_of(4'h0));
        rd_chk(8'(OFF_FIFO0 + 2 * OFF_STEP), word_of(4'h1));
        apb(1'b1, OFF_CTRL1, 32'h20);
        rd_chk(OFF_CTRL1, 32'h20);
        $display("test freeze done");
        test_done();
    end

    function automatic logic [7:0] OFF_SEL1_ADDR();
        return 8'(OFF_SEL0 + OFF_STEP);
    endfunction : OFF_SEL1_ADDR
endmodule : tb
